// ==== design/ldp_dim_gen.sv ====
module ldp_dim_gen #(
  parameter int STEP_CYCLES = ldp_pkg::DIM_STEP_CYCLES_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Duty threshold and waveform
  input wire logic [7:0] threshold,
  output logic dim_on
);
  localparam int PW = $clog2(STEP_CYCLES + 1);
  logic [PW-1:0] pre;
  logic [7:0] step;

  // One period is 255 steps, so threshold 255 never drops the waveform.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre <= '0;
      step <= 8'h00;
    end else if (pre == PW'(STEP_CYCLES - 1)) begin
      pre <= '0;
      step <= (step == 8'(ldp_pkg::DIM_STEPS - 1)) ? 8'h00 : step + 8'h01;
    end else begin
      pre <= pre + PW'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dim_on <= 1'b0;
    end else begin
      dim_on <= step < threshold;
    end
  end
endmodule : ldp_dim_gen

// ==== design/ldp_link_if.sv ====
interface ldp_link_if;
  logic wr_toggle;
  logic [7:0] wr_offset;
  logic [7:0] wr_data;
  logic [1:0] status;
  modport link (output wr_toggle, output wr_offset, output wr_data, input status);
  modport core (input wr_toggle, input wr_offset, input wr_data, output status);
endinterface : ldp_link_if

// ==== design/ldp_pkg.sv ====
package ldp_pkg;
  localparam int CLK_HZ = 40_000_000;
  // Register offsets.
  localparam logic [7:0] OFS_PWM_BRIGHTNESS = 8'h00;
  localparam logic [7:0] OFS_SOURCE_SELECT = 8'h01;
  localparam logic [7:0] OFS_STATUS = 8'h02;
  localparam logic [7:0] OFS_DC_CURRENT = 8'h07;
  localparam logic [7:0] OFS_DRIVER_CONFIG = 8'h08;
  // Reset values.
  localparam logic [7:0] RST_PWM_BRIGHTNESS = 8'hFF;
  localparam logic [7:0] RST_SOURCE_SELECT = 8'h01;
  localparam logic [7:0] RST_DC_CURRENT = 8'hFF;
  localparam logic [7:0] RST_DRIVER_CONFIG = 8'h00;
  // Field positions.
  localparam int CFG_BOOST_SLOW_BIT = 2;
  localparam int STAT_ENABLED_BIT = 0;
  localparam int STAT_LED_ON_BIT = 1;
  // Dimming source codes.
  localparam logic [7:0] MODE_RATIO = 8'h01;
  localparam logic [7:0] MODE_EXTERNAL = 8'h03;
  localparam logic [7:0] MODE_INTERNAL = 8'h05;
  localparam logic [7:0] MODE_DC_TO_PWM = 8'h07;
  // Timing.
  localparam int EN_PULSE_NS = 40_000;
  localparam int EN_PULSE_CYCLES = (EN_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int LOW_TIMEOUT_MS = 28;
  localparam int LOW_TIMEOUT_CYCLES = LOW_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int BOOST_FAST_KHZ = 1200;
  localparam int BOOST_SLOW_KHZ = 600;
  localparam int BOOST_FAST_HALF = CLK_HZ / (2 * BOOST_FAST_KHZ * 1000);
  localparam int BOOST_SLOW_HALF = CLK_HZ / (2 * BOOST_SLOW_KHZ * 1000);
  localparam int DIM_STEPS = 255;
  localparam int DIM_STEP_CYCLES_DEF = 784;
  // Filter node window in millivolts.
  localparam logic [10:0] FILT_LOW_MV = 11'd210;
  localparam logic [10:0] FILT_HIGH_MV = 11'd1210;
  // Bus address; the value is arbitrary.
  localparam logic [6:0] SMB_ADDR_DEF = 7'h2C;

  typedef enum logic [2:0] {
    EN_OFF = 3'b001,
    EN_QUAL = 3'b010,
    EN_ON = 3'b100
  } ldp_en_e;

  typedef enum logic [4:0] {
    LNK_IDLE = 5'b00001,
    LNK_ADDR = 5'b00010,
    LNK_CMD = 5'b00100,
    LNK_DATA = 5'b01000,
    LNK_READ = 5'b10000
  } ldp_lnk_e;
endpackage : ldp_pkg

// ==== design/ldp_smbus_link.sv ====
module ldp_smbus_link #(
  parameter logic [6:0] DEV_ADDR = ldp_pkg::SMB_ADDR_DEF
) (
  // Reset
  input wire logic rst,
  // Serial bus pins
  input wire logic smb_clk,
  input wire logic smb_dat_in,
  output logic smb_dat_out,
  output logic smb_dat_oe,
  // Core side
  ldp_link_if.link lnk
);
  ldp_pkg::ldp_lnk_e state;
  logic start_tog;
  logic start_ack;
  logic byte_done;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] offset;
  logic [7:0] tx;
  logic [7:0] sh_brt;
  logic [7:0] sh_src;
  logic [7:0] sh_dc;
  logic [7:0] sh_cfg;
  logic [1:0] stat_meta;
  logic [1:0] stat_sync;

  // Readback comes from shadows of the written values; only the two status bits cross back, each through two flops.
  function automatic logic [7:0] rd(input logic [7:0] ofs);
    case (ofs)
      ldp_pkg::OFS_PWM_BRIGHTNESS: rd = sh_brt;
      ldp_pkg::OFS_SOURCE_SELECT: rd = sh_src;
      ldp_pkg::OFS_STATUS: rd = {6'h00, stat_sync};
      ldp_pkg::OFS_DC_CURRENT: rd = sh_dc;
      ldp_pkg::OFS_DRIVER_CONFIG: rd = sh_cfg;
      default: rd = 8'h00;
    endcase
  endfunction : rd

  assign smb_dat_out = 1'b0;
  assign byte_done = (start_tog == start_ack) && (bit_cnt == 4'd8);

  // A start is the data line falling while the bus clock is high.
  always_ff @(negedge smb_dat_in or posedge rst) begin
    if (rst) begin
      start_tog <= 1'b0;
    end else if (smb_clk) begin
      start_tog <= ~start_tog;
    end
  end

  always_ff @(posedge smb_clk or posedge rst) begin
    if (rst) begin
      stat_meta <= 2'b00;
      stat_sync <= 2'b00;
    end else begin
      stat_meta <= lnk.status;
      stat_sync <= stat_meta;
    end
  end

  always_ff @(posedge smb_clk or posedge rst) begin
    if (rst) begin
      state <= ldp_pkg::LNK_IDLE;
      start_ack <= 1'b0;
      bit_cnt <= 4'd0;
      shift <= 8'h00;
      offset <= 8'h00;
      tx <= 8'h00;
    end else if (start_tog != start_ack) begin
      start_ack <= start_tog;
      state <= ldp_pkg::LNK_ADDR;
      bit_cnt <= 4'd1;
      shift <= {7'h00, smb_dat_in};
    end else if (bit_cnt != 4'd8) begin
      shift <= {shift[6:0], smb_dat_in};
      bit_cnt <= bit_cnt + 4'd1;
    end else begin
      bit_cnt <= 4'd0;
      case (state)
        ldp_pkg::LNK_ADDR: begin
          if (shift[7:1] != DEV_ADDR) begin
            state <= ldp_pkg::LNK_IDLE;
          end else if (shift[0]) begin
            state <= ldp_pkg::LNK_READ;
            tx <= rd(offset);
          end else begin
            state <= ldp_pkg::LNK_CMD;
          end
        end
        ldp_pkg::LNK_CMD: begin
          offset <= shift;
          state <= ldp_pkg::LNK_DATA;
        end
        ldp_pkg::LNK_DATA: offset <= offset + 8'h01;
        ldp_pkg::LNK_READ: begin
          if (smb_dat_in) begin
            state <= ldp_pkg::LNK_IDLE;
          end else begin
            offset <= offset + 8'h01;
            tx <= rd(offset + 8'h01);
          end
        end
        default: state <= ldp_pkg::LNK_IDLE;
      endcase
    end
  end

  // Offset and data are held until the next write, many bus clocks later.
  always_ff @(posedge smb_clk or posedge rst) begin
    if (rst) begin
      lnk.wr_toggle <= 1'b0;
      lnk.wr_offset <= 8'h00;
      lnk.wr_data <= 8'h00;
      sh_brt <= ldp_pkg::RST_PWM_BRIGHTNESS;
      sh_src <= ldp_pkg::RST_SOURCE_SELECT;
      sh_dc <= ldp_pkg::RST_DC_CURRENT;
      sh_cfg <= ldp_pkg::RST_DRIVER_CONFIG;
    end else if (byte_done && state == ldp_pkg::LNK_DATA) begin
      lnk.wr_toggle <= ~lnk.wr_toggle;
      lnk.wr_offset <= offset;
      lnk.wr_data <= shift;
      if (offset == ldp_pkg::OFS_PWM_BRIGHTNESS) sh_brt <= shift;
      if (offset == ldp_pkg::OFS_SOURCE_SELECT) sh_src <= shift;
      if (offset == ldp_pkg::OFS_DC_CURRENT) sh_dc <= shift;
      if (offset == ldp_pkg::OFS_DRIVER_CONFIG) sh_cfg <= shift;
    end
  end

  // Data changes only while the bus clock is low.
  always_ff @(negedge smb_clk or posedge rst) begin
    if (rst) begin
      smb_dat_oe <= 1'b0;
    end else if (bit_cnt == 4'd8) begin
      smb_dat_oe <= (state == ldp_pkg::LNK_ADDR && shift[7:1] == DEV_ADDR) ||
                    state == ldp_pkg::LNK_CMD || state == ldp_pkg::LNK_DATA;
    end else if (state == ldp_pkg::LNK_READ) begin
      smb_dat_oe <= ~tx[3'd7 - bit_cnt[2:0]];
    end else begin
      smb_dat_oe <= 1'b0;
    end
  end
endmodule : ldp_smbus_link

// ==== design/ldp_top.sv ====
// How it works
// - Eight-bit DC current code, range 0 to 255, resets to 255, sets on-current.
// - The DC current code may change while running and applies at once.
// - DC current code zero turns every channel off.
// - Brightness code at offset 0x00 resets to 255; zero turns channels off in every source but 0x03.
// - The internal dimming waveform has 255 duty steps from the brightness code.
// - Source code 0x05 with the pin held high dims from brightness code alone.
// - Source code 0x03 chops the current directly with the external input.
// - Source code 0x01 combines external duty with the brightness code.
// - After reset the ratiometric source is active.
// - Ratiometric duty is brightness over 255 times external duty, internal rate.
// - All eight channels are gated together at the DC current level.
// - An external low interval beyond 28 ms shuts the device down.
// - External mode follows the pin's rate; other modes use the internal rate.
// - DC-to-PWM duty falls linearly from full at 0.21 V to zero at 1.21 V.
// - Config bit 2 picks a 600 kHz or 1.2 MHz boost clock, 1.2 MHz after reset.
// - A first high pulse of 40 us enables; 28 ms without signal shuts down.
module ldp_top #(
  parameter int LOW_TIMEOUT_CYCLES = ldp_pkg::LOW_TIMEOUT_CYCLES,
  parameter int DIM_STEP_CYCLES = ldp_pkg::DIM_STEP_CYCLES_DEF,
  parameter logic [6:0] DEV_ADDR = ldp_pkg::SMB_ADDR_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial bus
  input wire logic smb_clk,
  input wire logic smb_dat_in,
  output logic smb_dat_out,
  output logic smb_dat_oe,
  // Dimming inputs
  input wire logic enable_dim_pin,
  input wire logic [10:0] dim_filter_mv,
  // LED string drive
  output logic [7:0] led_gate,
  output logic [7:0] led_current_level,
  output logic device_enabled,
  // Boost converter
  output logic boost_slow_sel,
  output logic boost_switch_clk
);
  localparam int QW = $clog2(ldp_pkg::EN_PULSE_CYCLES);
  localparam int LW = $clog2(LOW_TIMEOUT_CYCLES + 1);
  localparam int BW = $clog2(ldp_pkg::BOOST_SLOW_HALF + 1);

  ldp_link_if lnk ();
  ldp_pkg::ldp_en_e en_state;
  logic wr_meta;
  logic wr_sync;
  logic wr_seen;
  logic wr_pulse;
  logic pin_meta;
  logic pin_s;
  logic pin_d;
  logic [7:0] brt_code;
  logic [7:0] src_sel;
  logic [7:0] dc_code;
  logic [7:0] cfg;
  logic [QW-1:0] qual_cnt;
  logic [LW-1:0] low_cnt;
  logic [LW-1:0] per_cnt;
  logic [LW-1:0] high_cnt;
  logic [7:0] ext_frac;
  logic [7:0] filt_frac;
  logic [7:0] thr;
  logic [7:0] next_thr;
  logic dim_on;
  logic src_on;
  logic [BW-1:0] boost_cnt;
  logic any_write;

  // Restoring division giving high time over period as an 8-bit fraction.
  function automatic logic [7:0] ldp_frac(input logic [LW-1:0] num, input logic [LW-1:0] den);
    logic [LW:0] rem;
    logic [7:0] q;
    rem = {1'b0, num};
    q = 8'h00;
    if (num >= den) begin
      q = 8'hFF;
    end else begin
      for (int i = 7; i >= 0; i--) begin
        rem = rem << 1;
        if (rem >= {1'b0, den}) begin
          rem = rem - {1'b0, den};
          q[i] = 1'b1;
        end
      end
    end
    return q;
  endfunction : ldp_frac

  // Exact floor of a * b / 255 for 8-bit operands.
  function automatic logic [7:0] ldp_scale255(input logic [7:0] a, input logic [7:0] b);
    logic [16:0] p;
    p = 17'(a) * 17'(b);
    p = p + (p >> 8) + 17'd1;
    return p[15:8];
  endfunction : ldp_scale255

  ldp_smbus_link #(
    .DEV_ADDR(DEV_ADDR)
  ) u_link (
    .rst(rst),
    .smb_clk(smb_clk),
    .smb_dat_in(smb_dat_in),
    .smb_dat_out(smb_dat_out),
    .smb_dat_oe(smb_dat_oe),
    .lnk(lnk.link)
  );

  // Write events arrive as a toggle from the bus clock domain.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_meta <= 1'b0;
      wr_sync <= 1'b0;
      wr_seen <= 1'b0;
    end else begin
      wr_meta <= lnk.wr_toggle;
      wr_sync <= wr_meta;
      wr_seen <= wr_sync;
    end
  end
  assign wr_pulse = wr_sync ^ wr_seen;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      brt_code <= ldp_pkg::RST_PWM_BRIGHTNESS;
      src_sel <= ldp_pkg::RST_SOURCE_SELECT;
      dc_code <= ldp_pkg::RST_DC_CURRENT;
      cfg <= ldp_pkg::RST_DRIVER_CONFIG;
    end else if (wr_pulse) begin
      case (lnk.wr_offset)
        ldp_pkg::OFS_PWM_BRIGHTNESS: brt_code <= lnk.wr_data;
        ldp_pkg::OFS_SOURCE_SELECT: src_sel <= lnk.wr_data;
        ldp_pkg::OFS_DC_CURRENT: dc_code <= lnk.wr_data;
        ldp_pkg::OFS_DRIVER_CONFIG: cfg <= lnk.wr_data;
        default: cfg <= cfg;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      any_write <= 1'b0;
    end else if (wr_pulse) begin
      any_write <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_meta <= 1'b0;
      pin_s <= 1'b0;
      pin_d <= 1'b0;
    end else begin
      pin_meta <= enable_dim_pin;
      pin_s <= pin_meta;
      pin_d <= pin_s;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_state <= ldp_pkg::EN_OFF;
      qual_cnt <= '0;
      low_cnt <= '0;
    end else begin
      case (en_state)
        ldp_pkg::EN_OFF: begin
          qual_cnt <= '0;
          low_cnt <= '0;
          if (pin_s) en_state <= ldp_pkg::EN_QUAL;
        end
        ldp_pkg::EN_QUAL: begin
          if (!pin_s) begin
            en_state <= ldp_pkg::EN_OFF;
          end else if (qual_cnt == QW'(ldp_pkg::EN_PULSE_CYCLES - 1)) begin
            en_state <= ldp_pkg::EN_ON;
          end else begin
            qual_cnt <= qual_cnt + QW'(1);
          end
        end
        ldp_pkg::EN_ON: begin
          if (pin_s) begin
            low_cnt <= '0;
          end else if (low_cnt == LW'(LOW_TIMEOUT_CYCLES - 1)) begin
            en_state <= ldp_pkg::EN_OFF;
          end else begin
            low_cnt <= low_cnt + LW'(1);
          end
        end
        default: en_state <= ldp_pkg::EN_OFF;
      endcase
    end
  end
  assign device_enabled = (en_state == ldp_pkg::EN_ON);

  // External duty is measured rise to rise; a stuck pin reads as 0 or full.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      per_cnt <= '0;
      high_cnt <= '0;
      ext_frac <= 8'hFF;
    end else if (pin_s && !pin_d) begin
      ext_frac <= ldp_frac(high_cnt, per_cnt);
      per_cnt <= LW'(1);
      high_cnt <= LW'(1);
    end else if (&per_cnt) begin
      ext_frac <= pin_s ? 8'hFF : 8'h00;
    end else begin
      per_cnt <= per_cnt + LW'(1);
      high_cnt <= high_cnt + LW'(pin_s);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filt_frac <= 8'hFF;
    end else if (dim_filter_mv <= ldp_pkg::FILT_LOW_MV) begin
      filt_frac <= 8'hFF;
    end else if (dim_filter_mv >= ldp_pkg::FILT_HIGH_MV) begin
      filt_frac <= 8'h00;
    end else begin
      filt_frac <= 8'((18'(ldp_pkg::FILT_HIGH_MV - dim_filter_mv) * 18'd255) / 18'd1000);
    end
  end

  always_comb begin
    case (src_sel)
      ldp_pkg::MODE_INTERNAL: next_thr = brt_code;
      ldp_pkg::MODE_DC_TO_PWM: next_thr = ldp_scale255(brt_code, filt_frac);
      default: next_thr = ldp_scale255(brt_code, ext_frac);
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      thr <= 8'hFF;
    end else begin
      thr <= next_thr;
    end
  end

  ldp_dim_gen #(
    .STEP_CYCLES(DIM_STEP_CYCLES)
  ) u_dim (
    .clk(clk),
    .rst(rst),
    .threshold(thr),
    .dim_on(dim_on)
  );

  assign src_on = (src_sel == ldp_pkg::MODE_EXTERNAL) ? pin_s : dim_on;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      led_gate <= 8'h00;
    end else begin
      led_gate <= (device_enabled && dc_code != 8'h00 && src_on) ? 8'hFF : 8'h00;
    end
  end

  // current level follows the code live
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      led_current_level <= ldp_pkg::RST_DC_CURRENT;
    end else begin
      led_current_level <= dc_code;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      boost_slow_sel <= 1'b0;
      boost_cnt <= '0;
      boost_switch_clk <= 1'b0;
    end else begin
      boost_slow_sel <= cfg[ldp_pkg::CFG_BOOST_SLOW_BIT];
      if (boost_cnt >= (boost_slow_sel ? BW'(ldp_pkg::BOOST_SLOW_HALF - 1) :
                                         BW'(ldp_pkg::BOOST_FAST_HALF - 1))) begin
        boost_cnt <= '0;
        boost_switch_clk <= ~boost_switch_clk;
      end else begin
        boost_cnt <= boost_cnt + BW'(1);
      end
    end
  end

  assign lnk.status = {led_gate[0], device_enabled};

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence pulse_done_s;
    en_state == ldp_pkg::EN_QUAL && pin_s && qual_cnt == QW'(ldp_pkg::EN_PULSE_CYCLES - 1);
  endsequence
  sequence low_expired_s;
    device_enabled && !pin_s && low_cnt == LW'(LOW_TIMEOUT_CYCLES - 1);
  endsequence

  dc_zero_off_a: assert property (dc_code == 8'h00 |=> led_gate == 8'h00)
    else $error("Gates on with zero current code.");
  level_track_a: assert property (##1 led_current_level == $past(dc_code))
    else $error("Current level does not follow the code.");
  gate_uniform_a: assert property (led_gate == 8'h00 || led_gate == 8'hFF)
    else $error("Channels gated unequally.");
  brt_zero_off_a: assert property (
    (src_sel == ldp_pkg::MODE_INTERNAL && brt_code == 8'h00)[*4] |-> led_gate == 8'h00
  )
    else $error("Gates on with zero brightness code.");
  full_on_a: assert property (
    (src_sel == ldp_pkg::MODE_INTERNAL && brt_code == 8'hFF && dc_code != 8'h00 &&
     device_enabled)[*4] |-> led_gate == 8'hFF
  )
    else $error("Full brightness code did not hold channels on.");
  ext_follow_a: assert property (
    src_sel == ldp_pkg::MODE_EXTERNAL && device_enabled && dc_code != 8'h00
    |=> led_gate == {8{$past(pin_s)}}
  )
    else $error("External mode gate does not follow the pin.");
  ratio_zero_a: assert property (
    (src_sel == ldp_pkg::MODE_RATIO && ext_frac == 8'h00)[*4] |-> led_gate == 8'h00
  )
    else $error("Ratiometric output on with zero external duty.");
  filt_high_off_a: assert property (
    (src_sel == ldp_pkg::MODE_DC_TO_PWM && dim_filter_mv >= ldp_pkg::FILT_HIGH_MV)[*5]
    |-> led_gate == 8'h00
  )
    else $error("Filter voltage above window did not stop dimming output.");
  reset_ratio_a: assert property (!any_write |-> src_sel == ldp_pkg::MODE_RATIO)
    else $error("Reset source is not ratiometric.");
  enable_pulse_a: assert property (pulse_done_s |=> device_enabled ##1 lnk.status[0])
    else $error("Qualified pulse did not enable the device.");
  low_shutdown_a: assert property (
    low_expired_s |=> en_state == ldp_pkg::EN_OFF ##1 led_gate == 8'h00
  )
    else $error("Long low interval did not shut down.");
  boost_sel_a: assert property (
    ##1 boost_slow_sel == $past(cfg[ldp_pkg::CFG_BOOST_SLOW_BIT])
  )
    else $error("Boost clock select does not follow config bit.");
endmodule : ldp_top

// ==== testbench/ldp_host_model.sv ====
module ldp_host_model #(
  parameter logic [6:0] ADDR = 7'h2C
) (
  // Bus wires
  output logic smb_clk,
  output logic smb_dat_in,
  input wire logic smb_dat_oe,
  // Dimming pin
  output logic enable_dim_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic pull;
  // The data wire has a pull-up, so a released line reads high.
  assign smb_dat_in = ~(pull | smb_dat_oe);
  initial begin
    smb_clk = 1'b1;
    pull = 1'b0;
    enable_dim_pin = 1'b0;
  end
  task automatic clk_bit(input logic drv, output logic got);
    smb_clk = 1'b0;
    pull = ~drv;
    #7.5;
    got = smb_dat_in;
    smb_clk = 1'b1;
    #7.5;
  endtask : clk_bit
  task automatic start_bit();
    smb_clk = 1'b0;
    pull = 1'b0;
    #7.5;
    smb_clk = 1'b1;
    #7.5;
    pull = 1'b1;
    #7.5;
  endtask : start_bit
  task automatic stop_bit();
    smb_clk = 1'b0;
    pull = 1'b1;
    #7.5;
    smb_clk = 1'b1;
    #7.5;
    pull = 1'b0;
    #7.5;
  endtask : stop_bit
  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(v[i], g);
    end
    clk_bit(1'b1, g);
    ack = ~g;
  endtask : send_byte
  task automatic write_reg(input logic [7:0] ofs, input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start_bit();
    send_byte({ADDR, 1'b0}, a0);
    send_byte(ofs, a1);
    send_byte(d, a2);
    stop_bit();
    ok = a0 & a1 & a2;
  endtask : write_reg
  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d, output logic ok);
    logic a0, a1, a2, g;
    start_bit();
    send_byte({ADDR, 1'b0}, a0);
    send_byte(ofs, a1);
    start_bit();
    send_byte({ADDR, 1'b1}, a2);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, d[i]);
    end
    // A released acknowledge bit tells the device the read is over.
    clk_bit(1'b1, g);
    stop_bit();
    ok = a0 & a1 & a2;
  endtask : read_reg
  task automatic pin(input logic v);
    enable_dim_pin = v;
  endtask : pin
  task automatic ext_pwm(input int hi_ns, input int lo_ns, input int n);
    repeat (n) begin
      enable_dim_pin = 1'b1;
      #(hi_ns);
      enable_dim_pin = 1'b0;
      #(lo_ns);
    end
    enable_dim_pin = 1'b1;
  endtask : ext_pwm
endmodule : ldp_host_model

// ==== testbench/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int STEP = 2;
  localparam int PER = 255 * STEP;
  logic clk, rst, smb_clk, smb_dat_in, smb_dat_out, smb_dat_oe, enable_dim_pin;
  logic [10:0] dim_filter_mv;
  logic [7:0] led_gate, led_current_level;
  logic device_enabled, boost_slow_sel, boost_switch_clk;
  int fail_count, total_checks, on_cnt, odd_cnt, tog_cnt;
  logic [7:0] pwm_brightness_code [4] = '{8'h00, 8'h01, 8'h80, 8'hFF};
  int mv [3] = '{210, 710, 1210};
  int mv_on [3] = '{510, 254, 0};
  ldp_top #(.LOW_TIMEOUT_CYCLES(200), .DIM_STEP_CYCLES(STEP)) dut (.clk(clk), .rst(rst),
    .smb_clk(smb_clk), .smb_dat_in(smb_dat_in), .smb_dat_out(smb_dat_out),
    .smb_dat_oe(smb_dat_oe), .enable_dim_pin(enable_dim_pin), .dim_filter_mv(dim_filter_mv),
    .led_gate(led_gate), .led_current_level(led_current_level),
    .device_enabled(device_enabled), .boost_slow_sel(boost_slow_sel),
    .boost_switch_clk(boost_switch_clk));
  ldp_host_model host (.smb_clk(smb_clk), .smb_dat_in(smb_dat_in), .smb_dat_oe(smb_dat_oe),
    .enable_dim_pin(enable_dim_pin));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_n(input string what, input int exp, input int got, input int tol);
    total_checks++;
    if (got < exp - tol || got > exp + tol) begin
      fail_count++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_n
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    logic ok;
    host.write_reg(ofs, d, ok);
    chk("write ack", 8'h01, {7'h00, ok});
    // The register crosses into the system clock a few cycles after the acknowledge.
    repeat (10) @(negedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
    logic [7:0] v;
    logic ok;
    host.read_reg(ofs, v, ok);
    chk("read ack", 8'h01, {7'h00, ok});
    chk("read data", exp, v);
  endtask : rd
  task automatic measure(input int n);
    logic last;
    on_cnt = 0;
    tog_cnt = 0;
    last = boost_switch_clk;
    repeat (n) begin
      @(negedge clk);
      if (led_gate === 8'hFF) on_cnt++;
      else if (led_gate !== 8'h00) odd_cnt++;
      if (boost_switch_clk !== last) tog_cnt++;
      last = boost_switch_clk;
    end
  endtask : measure
  initial begin
    #1_000_000;
    fail_count++;
    $display("MISMATCH watchdog expected done seen hang");
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    dim_filter_mv = 11'd210;
    fail_count = 0;
    total_checks = 0;
    odd_cnt = 0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk("dc level", 8'hFF, led_current_level);
    chk("boost sel", 8'h00, {7'h00, boost_slow_sel});
    rd(8'h00, 8'hFF);
    rd(8'h01, 8'h01);
    rd(8'h07, 8'hFF);
    rd(8'h08, 8'h00);
    rd(8'h05, 8'h00);
    @(negedge clk);
    host.pin(1'b1);
    repeat (1500) @(negedge clk);
    chk("enabled", 8'h00, {7'h00, device_enabled});
    repeat (200) @(negedge clk);
    chk("enabled", 8'h01, {7'h00, device_enabled});
    wr(8'h01, 8'h05);
    foreach (pwm_brightness_code[i]) begin
      wr(8'h00, pwm_brightness_code[i]);
      measure(PER);
      chk_n("internal on", pwm_brightness_code[i] * STEP, on_cnt, 0);
    end
    rd(8'h02, 8'h03);
    wr(8'h07, 8'h40);
    chk("dc level", 8'h40, led_current_level);
    wr(8'h07, 8'h00);
    measure(PER);
    chk_n("dc zero on", 0, on_cnt, 0);
    chk_n("boost toggles", PER / ldp_pkg::BOOST_FAST_HALF, tog_cnt, 1);
    wr(8'h07, 8'hFF);
    wr(8'h08, 8'h04);
    chk("boost sel", 8'h01, {7'h00, boost_slow_sel});
    measure(PER);
    chk_n("boost toggles", PER / ldp_pkg::BOOST_SLOW_HALF, tog_cnt, 1);
    rd(8'h08, 8'h04);
    wr(8'h08, 8'h00);
    wr(8'h01, 8'h07);
    foreach (mv[i]) begin
      dim_filter_mv = mv[i][10:0];
      repeat (10) @(negedge clk);
      measure(PER);
      chk_n("filter on", mv_on[i], on_cnt, 0);
    end
    wr(8'h01, 8'h03);
    fork
      host.ext_pwm(600, 1400, 12);
      begin
        repeat (80) @(negedge clk);
        measure(800);
      end
    join
    chk_n("external on", 240, on_cnt, 6);
    wr(8'h00, 8'h80);
    wr(8'h01, 8'h01);
    fork
      host.ext_pwm(1000, 1000, 20);
      begin
        repeat (600) @(negedge clk);
        measure(PER);
      end
    join
    chk_n("ratio on", 128, on_cnt, 4);
    chk_n("split gate", 0, odd_cnt, 0);
    wr(8'h01, 8'h03);
    host.pin(1'b0);
    repeat (150) @(negedge clk);
    chk("enabled", 8'h01, {7'h00, device_enabled});
    repeat (60) @(negedge clk);
    chk("enabled", 8'h00, {7'h00, device_enabled});
    chk("gate", 8'h00, led_gate);
    wrap_up();
  end
endmodule : tb
